// ===== include/adc_seq_pkg.sv
// Purpose: Shared constants and types for the converter sequencer control block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses; registers are eight bits wide in the low lanes.
package adc_seq_pkg;
    // Register byte offsets (printed offsets 70h, 71h, 72h are indices; byte address is four times).
    localparam logic [7:0] CSR_INDEX = 8'h70;
    localparam logic [7:0] RESULT_HIGH_INDEX = 8'h71;
    localparam logic [7:0] RESULT_LOW_INDEX = 8'h72;
    localparam logic [11:0] CSR_ADDR = {2'h0, CSR_INDEX, 2'h0};
    localparam logic [11:0] RESULT_HIGH_ADDR = {2'h0, RESULT_HIGH_INDEX, 2'h0};
    localparam logic [11:0] RESULT_LOW_ADDR = {2'h0, RESULT_LOW_INDEX, 2'h0};
    // Control/status field positions.
    localparam int DONE_BIT = 7;
    localparam int RATE_BIT = 6;
    localparam int ON_BIT = 5;
    localparam int RESERVED_BIT = 4;
    localparam int CHANNEL_LSB = 0;
    localparam int CHANNEL_WIDTH = 4;
    // Reset values.
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    // Converter clock dividers: rate bit zero gives divide by four, one gives divide by two.
    localparam logic [1:0] DIV_SLOW_LAST = 2'h3;
    localparam logic [1:0] DIV_FAST_LAST = 2'h1;
    // Converter clock cycles per conversion, from start or restart to the done flag.
    localparam logic [4:0] CONV_CYCLES = 5'h0e;
    // Settling time after leaving halt, in nanoseconds, and its count in 8 ns cycles.
    localparam int SETTLE_TIME_NS = 1000;
    localparam int SYS_CLK_PERIOD_NS = 8;
    localparam logic [7:0] SETTLE_CYCLES = 8'((SETTLE_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);
    // Sequencer states.
    typedef enum logic [1:0] {ST_OFF, ST_SETTLE, ST_CONVERT} seq_state_t;
endpackage : adc_seq_pkg

// ===== core/adc_clock_divider.sv
// Purpose: Makes the one-cycle converter clock tick from the system clock.
// Assumes: Synchronous active-high reset; clear restarts the count.
// Notes: The tick is a strobe, not a clock, so the whole block stays in one domain.
`timescale 1ns/100ps
module adc_clock_divider
    import adc_seq_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clear_i,
    input wire logic fast_i,
    output logic tick_o
);
    // All state of the divider in one record.
    typedef struct packed {
        logic [1:0] count;
        logic tick;
    } div_state_t;

    div_state_t state_r;
    div_state_t state_nxt;

    // Count up to the chosen terminal value and pulse once per wrap.
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.tick = 1'b0;
        if (clear_i)
        begin
            // Restart one step in: the registered start costs one cycle, so a conversion
            // lasts exactly its converter clocks from start to start.
            state_nxt.count = 2'h1;
        end
        else if (state_r.count >= (fast_i ? DIV_FAST_LAST : DIV_SLOW_LAST))
        begin
            state_nxt.count = 2'h0;
            state_nxt.tick = 1'b1;
        end
        else
        begin
            state_nxt.count = state_r.count + 2'h1;
        end
    end

    // Register the divider state.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign tick_o = state_r.tick;
endmodule : adc_clock_divider

// ===== core/adc_result_store.sv
// Purpose: Holds the ten-bit result and presents it as the high and low result bytes.
// Assumes: Load strobe comes one cycle wide from the sequencer.
// Notes: Not latched against reading; each load overwrites both bytes.
`timescale 1ns/100ps
module adc_result_store
    import adc_seq_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic load_i,
    input wire logic [9:0] data_i,
    output logic [7:0] high_o,
    output logic [7:0] low_o
);
    // The stored word is the only state.
    typedef struct packed {
        logic [9:0] word;
    } store_state_t;

    store_state_t state_r;
    store_state_t state_nxt;

    // A new result replaces the old one whole.
    always_comb
    begin
        state_nxt = state_r;
        if (load_i)
        begin
            state_nxt.word = data_i;
        end
    end

    // Register the stored result.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            state_r.word <= RESULT_RESET;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Upper eight bits high; two bits low with zeros above them.
    assign high_o = state_r.word[9:2];
    assign low_o = {6'h00, state_r.word[1:0]};
endmodule : adc_result_store

// ===== core/adc_sequencer_control.sv
// Purpose: Control logic for a ten-bit successive approximation converter with sixteen inputs.
// Assumes: APB slave, inputs synchronous to sys_clk_i, analog core answers with a ten-bit code.
// Notes: The analog core reports full scale and zero itself; this block passes codes through.
//
// Operation
// - High result holds result bits nine to two.
// - Low result holds bits one, zero; rest zero.
// - Over upper reference reads FFh, 03h, no overflow.
// - Under lower reference reads zero in both.
// - Converter-on starts continuous conversion of channel.
// - Clearing converter-on stops conversion, powers down.
// - Each completion sets done and updates results (a completion in the same cycle as a control write does neither).
// - High read or control write clears done (a completion in the same cycle as a high read leaves done set).
// - Channel change aborts, clears done, restarts conversion.
// - Channel field is plain binary input index.
// - Rate bit zero divides by four, one by two.
// - Done bit read-only; other control bits writable.
// - Results not latched; each completion overwrites.
// - Wait mode does not affect conversion.
// - Halt disables converter; settle after wake-up.
// - Reset clears control and result registers.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module adc_sequencer_control
    import adc_seq_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // APB slave port.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Processor low-power state.
    input wire logic wait_mode_i,
    input wire logic halt_mode_i,
    // Analog core side.
    input wire logic [9:0] conv_code_i,
    output logic [3:0] analog_input_n_o,
    output logic converter_power_o,
    output logic sample_start_o,
    output logic converter_tick_o,
    output logic conversion_active_o
);
    // All sequencer state in one record.
    typedef struct packed {
        seq_state_t fsm;
        logic done;
        logic rate;
        logic on;
        logic [3:0] channel;
        logic [4:0] cycles;
        logic [7:0] settle;
        logic was_halted;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic start;
        logic tick_out;
        logic power;
        logic active;
    } ctl_state_t;

    ctl_state_t state_r;
    ctl_state_t state_nxt;

    logic tick;
    logic [7:0] high_byte;
    logic [7:0] low_byte;
    logic load;
    logic divider_clear;
    logic setup;
    logic wr_csr;
    logic rd_high;

    // Recognise a register address; used for the read mux and the error answer.
    function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] reg_addr);
        addr_hit = (addr == reg_addr);
    endfunction : addr_hit

    // Converter clock strobe; restarted with each conversion start.
    adc_clock_divider u_divider
    (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .clear_i(divider_clear),
        .fast_i(state_r.rate),
        .tick_o(tick)
    );

    // Result bytes built from the stored word.
    adc_result_store u_store
    (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .load_i(load),
        .data_i(conv_code_i),
        .high_o(high_byte),
        .low_o(low_byte)
    );

    // Bus phases: each access completes in its first access cycle.
    assign setup = psel_i && !penable_i;
    assign wr_csr = setup && pwrite_i && addr_hit(paddr_i, CSR_ADDR);
    assign rd_high = setup && !pwrite_i && addr_hit(paddr_i, RESULT_HIGH_ADDR);

    // Completion loads the store; the store is written in the same cycle as done rises.
    assign load = (state_r.fsm == ST_CONVERT) && tick && (state_r.cycles == CONV_CYCLES - 5'h1)
        && !wr_csr;
    assign divider_clear = state_nxt.start;

    // Next-state logic for control bits, sequencer and bus answers.
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.start = 1'b0;
        state_nxt.ready = 1'b0;
        state_nxt.slverr = 1'b0;
        state_nxt.tick_out = 1'b0;

        // Bus answer is formed in the setup cycle and shown in the access cycle.
        if (setup)
        begin
            state_nxt.ready = 1'b1;
            state_nxt.rdata = 32'h0000_0000;
            if (addr_hit(paddr_i, CSR_ADDR))
            begin
                state_nxt.rdata[7:0] = {state_r.done, state_r.rate, state_r.on, 1'b0, state_r.channel};
            end
            else if (addr_hit(paddr_i, RESULT_HIGH_ADDR))
            begin
                state_nxt.rdata[7:0] = high_byte;
            end
            else if (addr_hit(paddr_i, RESULT_LOW_ADDR))
            begin
                state_nxt.rdata[7:0] = low_byte;
            end
            else
            begin
                // Unmapped addresses answer with an error and zero data.
                state_nxt.slverr = 1'b1;
            end
        end

        // Sequencer; wait mode is deliberately not an input to it.
        case (state_r.fsm)
            ST_OFF:
            begin
                state_nxt.power = 1'b0;
                state_nxt.active = 1'b0;
                if (state_r.on && !halt_mode_i)
                begin
                    // Power up at once; after halt, start converting only once settle time has passed.
                    state_nxt.power = 1'b1;
                    state_nxt.settle = state_r.was_halted ? SETTLE_CYCLES : 8'h00;
                    state_nxt.fsm = ST_SETTLE;
                end
            end
            ST_SETTLE:
            begin
                if (state_r.settle == 8'h00)
                begin
                    state_nxt.was_halted = 1'b0;
                    state_nxt.fsm = ST_CONVERT;
                    state_nxt.cycles = 5'h00;
                    state_nxt.start = 1'b1;
                    state_nxt.active = 1'b1;
                end
                else
                begin
                    state_nxt.settle = state_r.settle - 8'h01;
                end
            end
            ST_CONVERT:
            begin
                if (tick)
                begin
                    state_nxt.tick_out = 1'b1;
                    if (state_r.cycles == CONV_CYCLES - 5'h1)
                    begin
                        // Done, then straight into the next conversion.
                        state_nxt.done = 1'b1;
                        state_nxt.cycles = 5'h00;
                        state_nxt.start = 1'b1;
                    end
                    else
                    begin
                        state_nxt.cycles = state_r.cycles + 5'h1;
                    end
                end
            end
            default:
            begin
                state_nxt.fsm = ST_OFF;
            end
        endcase

        // Reading the high result clears done; a new completion in the same cycle wins.
        if (rd_high && !load)
        begin
            state_nxt.done = 1'b0;
        end

        // Control write: done bit ignored from the bus, but the write clears it.
        if (wr_csr)
        begin
            state_nxt.done = 1'b0;
            state_nxt.rate = pwdata_i[RATE_BIT];
            state_nxt.on = pwdata_i[ON_BIT];
            state_nxt.channel = pwdata_i[CHANNEL_LSB +: CHANNEL_WIDTH];
            if (state_r.fsm == ST_CONVERT && pwdata_i[ON_BIT]
                && pwdata_i[CHANNEL_LSB +: CHANNEL_WIDTH] != state_r.channel)
            begin
                // Abort and restart on the new channel.
                state_nxt.cycles = 5'h00;
                state_nxt.start = 1'b1;
                state_nxt.tick_out = 1'b0;
            end
        end

        // Converter off or processor halted: stop at once and power down.
        if (!state_nxt.on || halt_mode_i)
        begin
            state_nxt.fsm = ST_OFF;
            state_nxt.power = 1'b0;
            state_nxt.active = 1'b0;
            state_nxt.start = 1'b0;
            state_nxt.tick_out = 1'b0;
            state_nxt.cycles = 5'h00;
        end
        if (halt_mode_i)
        begin
            state_nxt.was_halted = 1'b1;
        end
    end

    // Register every bit of state; reset clears control and answers.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            state_r <= '0;
            state_r.fsm <= ST_OFF;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from flip-flops.
    assign prdata_o = state_r.rdata;
    assign pready_o = state_r.ready;
    assign pslverr_o = state_r.slverr;
    assign analog_input_n_o = state_r.channel;
    assign converter_power_o = state_r.power;
    assign sample_start_o = state_r.start;
    assign converter_tick_o = state_r.tick_out;
    assign conversion_active_o = state_r.active;
endmodule : adc_sequencer_control

// ===== verif/adc_seq_sva.sv
// Purpose: Port-level checks on the converter control block.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Conversion progress is judged from the strobes sent to the core.
`timescale 1ns/100ps
module adc_seq_sva
    import adc_seq_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic halt_mode_i,
    input wire logic [3:0] analog_input_n_o,
    input wire logic converter_power_o,
    input wire logic sample_start_o,
    input wire logic converter_tick_o,
    input wire logic conversion_active_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // A control write in the setup cycle, where the slave takes it.
    sequence csr_write_s;
        psel_i && !penable_i && pwrite_i && paddr_i == CSR_ADDR;
    endsequence
    // A read answered in its access cycle.
    sequence read_ans_s(logic [11:0] a);
        pready_o && psel_i && !pwrite_i && paddr_i == a;
    endsequence
    // The channel output must follow the written field.
    property chan_p;
        logic [3:0] ch;
        (csr_write_s, ch = pwdata_i[3:0]) |-> ##2 analog_input_n_o == ch;
    endproperty
    // Power must follow the on bit while halt stays low.
    property power_p;
        logic on;
        (csr_write_s, on = pwdata_i[ON_BIT]) ##0 (!halt_mode_i)[*3] |-> converter_power_o == on;
    endproperty
    a_low_upper_zero: assert property (read_ans_s(RESULT_LOW_ADDR) |-> prdata_o[31:2] == 30'h0)
        else $error("low result upper bits not zero");
    a_reserved_reads_zero: assert property (read_ans_s(CSR_ADDR) |-> !prdata_o[4] && prdata_o[31:8] == 24'h0)
        else $error("control reserved bits not zero");
    a_channel_follows_write: assert property (chan_p)
        else $error("channel output differs from written field");
    a_power_follows_on: assert property (power_p)
        else $error("power does not follow on bit");
    a_halt_powers_down: assert property (halt_mode_i[*2] |-> !converter_power_o)
        else $error("converter powered during halt");
    a_off_stays_quiet: assert property (!converter_power_o[*2] |-> !conversion_active_o && !converter_tick_o)
        else $error("activity while powered down");
    a_start_when_active: assert property (sample_start_o |-> conversion_active_o && converter_power_o)
        else $error("start without active converter");
    a_tick_gap_held: assert property (converter_tick_o |=> !converter_tick_o)
        else $error("converter ticks back to back");
    a_tick_in_conversion: assert property (converter_tick_o |-> conversion_active_o)
        else $error("tick outside a conversion");
endmodule : adc_seq_sva

bind adc_sequencer_control adc_seq_sva u_sva (.sys_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .halt_mode_i, .analog_input_n_o, .converter_power_o, .sample_start_o,
    .converter_tick_o, .conversion_active_o);

// ===== verif/analog_core_model.sv
// Purpose: Behavioural analog core that answers with a code per channel.
// Assumes: Code is sampled by the block only at completion.
// Notes: Mode 1 is above the upper reference, mode 2 below the lower one.
`timescale 1ns/100ps
module analog_core_model (
    input wire logic sys_clk_i,
    input wire logic [3:0] channel_i,
    input wire logic power_i,
    input wire logic [1:0] mode_i,
    output logic [9:0] code_o
);
    initial code_o = 10'h155;
    // A powered-down core toggles its output so a stale code is never mistaken for a result.
    always @(posedge sys_clk_i)
    begin
        if (!power_i)
            code_o <= ~code_o;
        else if (mode_i == 2'h1)
            code_o <= 10'h3ff;
        else if (mode_i == 2'h2)
            code_o <= 10'h000;
        else
            code_o <= {channel_i, 6'h2d};
    end
endmodule : analog_core_model

// ===== verif/adc_sequencer_control_tb.sv
// Purpose: Register-level tests of the converter control block.
// Assumes: APB answers in the access cycle; a conversion takes a fixed count of converter clocks.
// Notes: Expected codes come from the core model's channel pattern.
`timescale 1ns/100ps
module adc_sequencer_control_tb;
    import adc_seq_pkg::*;
    logic sys_clk_i = 1'b0, reset_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, v, pgap = 32'h0, since = 32'h0;
    logic pready, pslverr, err, wait_mode = 1'b0, halt = 1'b0, power, start, active;
    logic [1:0] mode = 2'h0;
    logic [9:0] code;
    logic [3:0] chan;
    int n_fail = 0, compares = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    adc_sequencer_control dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .wait_mode_i(wait_mode), .halt_mode_i(halt), .conv_code_i(code),
        .analog_input_n_o(chan), .converter_power_o(power), .sample_start_o(start),
        .converter_tick_o(), .conversion_active_o(active));
    analog_core_model core (.sys_clk_i(sys_clk_i), .channel_i(chan), .power_i(power), .mode_i(mode), .code_o(code));
    // Cycles between conversion starts give the conversion period.
    always @(posedge sys_clk_i)
    begin
        if (start)
        begin
            pgap <= since;
            since <= 32'h1;
        end
        else
            since <= since + 32'h1;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer; the bounded wait on pready guards against a hang.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        do @(posedge sys_clk_i); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20)
            n_fail++;
        v = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk_i);
    endtask : apb
    // Polls the done flag a bounded number of times.
    task automatic wait_done();
        int n;
        n = 0;
        do apb(1'b0, CSR_ADDR, 32'h0); while (v[DONE_BIT] !== 1'b1 && ++n < 200);
        if (n >= 200)
            n_fail++;
    endtask : wait_done
    task automatic report_and_stop();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (20) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        apb(1'b0, CSR_ADDR, 32'h0); chk(v, 32'h0);
        apb(1'b0, RESULT_HIGH_ADDR, 32'h0); chk(v, 32'h0);
        apb(1'b0, RESULT_LOW_ADDR, 32'h0); chk(v, 32'h0);
        apb(1'b1, CSR_ADDR, 32'h8f);
        apb(1'b0, CSR_ADDR, 32'h0); chk(v, 32'h0f);
        wait_mode <= 1'b1;
        // Each channel after the first is written while the previous one still converts.
        for (int c = 0; c < 16; c++)
        begin
            if (c > 0)
                wait_done();
            apb(1'b1, CSR_ADDR, {24'h0, 1'b0, c[0], 2'h2, c[3:0]});
            apb(1'b0, CSR_ADDR, 32'h0); chk(v, {24'h0, 1'b0, c[0], 2'h2, c[3:0]});
            wait_done();
            chk(pgap, 32'(CONV_CYCLES) * (c[0] ? 32'h2 : 32'h4));
            apb(1'b0, RESULT_LOW_ADDR, 32'h0); chk(v, 32'h1);
            apb(1'b0, RESULT_HIGH_ADDR, 32'h0); chk(v, {24'h0, c[3:0], 4'hb});
            apb(1'b0, CSR_ADDR, 32'h0); chk({31'h0, v[DONE_BIT]}, 32'h0);
        end
        wait_mode <= 1'b0;
        // Eight-bit readout: poll done, then the high byte alone clears it.
        wait_done();
        apb(1'b0, RESULT_HIGH_ADDR, 32'h0); chk(v, 32'hfb);
        apb(1'b0, CSR_ADDR, 32'h0); chk({31'h0, v[DONE_BIT]}, 32'h0);
        // Full scale, then zero, each overwriting the previous result.
        for (int m = 1; m < 3; m++)
        begin
            mode <= 2'(m);
            apb(1'b1, CSR_ADDR, 32'h25);
            wait_done();
            apb(1'b0, RESULT_LOW_ADDR, 32'h0); chk(v, (m == 1) ? 32'h3 : 32'h0);
            apb(1'b0, RESULT_HIGH_ADDR, 32'h0); chk(v, (m == 1) ? 32'hff : 32'h0);
        end
        halt <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        chk({30'h0, power, active}, 32'h0);
        halt <= 1'b0;
        apb(1'b1, CSR_ADDR, 32'h0);
        repeat (4) @(posedge sys_clk_i);
        chk({30'h0, power, active}, 32'h0);
        apb(1'b0, 12'h000, 32'h0); chk({31'h0, err}, 32'h1);
        chk(v, 32'h0);
        report_and_stop();
    end
    // Watchdog well beyond the expected two thousand or so cycles.
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        n_fail++;
        report_and_stop();
    end
endmodule : adc_sequencer_control_tb
